// ---- hw/crb_rx_ctrl.sv ----
// Behaviour
// - assembly buffer captures every message at once, never stalled by receive buffers.
// - accepted message copies the whole assembly buffer into the target buffer.
// - target buffer full flag sets on the transfer edge.
// - full buffer is never loaded; firmware writes zero to release it.
// - with interrupt enabled, one pulse per message placed in a buffer.
// - filter hit index stored; four bits in fixed mode, five otherwise.
// - remote-request flag stored in the buffer control word.
// - extended-id flag stored in the buffer id word, set for extended.
// - four receive modes: field in fixed mode, mode bit plus mask type otherwise.
// - receive mode 00 takes filtered messages; fixed mode: filter type select must match.
// - fixed mode 01 takes standard only, 10 extended only.
// - programmable modes: mask type bit forces filter id type match.
// - mode 11 (fixed mode: buffers 0 and 1 only) or mode bit set accepts every message.
// - receive-all buffers also take errored partial frames.
// - programmable modes: hit on a filter owned by a transmit buffer discards.
// - fixed mode: buffer 0 high priority two filters, buffer 1 four filters.
// - fixed mode forwarding: full buffer 0 pushes message into free buffer 1, no overflow.
// - fixed mode: one mask per fixed buffer.
// - programmable modes: sixteen filters, each assignable to any buffer.
// - several accepting buffers: lowest number wins.
//
// Implementation choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module crb_rx_ctrl (
    // clock and reset
    input  wire logic               i_mclk,
    input  wire logic               i_reset,
    // protocol engine
    input  wire crb_pkg::crb_frame_t i_frame,
    input  wire logic               i_frame_done,
    input  wire logic               i_frame_err,
    // axi4-lite write
    input  wire logic [11:0]        i_awaddr,
    input  wire logic               i_awvalid,
    output logic                    o_awready,
    input  wire logic [31:0]        i_wdata,
    input  wire logic [3:0]         i_wstrb,
    input  wire logic               i_wvalid,
    output logic                    o_wready,
    output logic [1:0]              o_bresp,
    output logic                    o_bvalid,
    input  wire logic               i_bready,
    // axi4-lite read
    input  wire logic [11:0]        i_araddr,
    input  wire logic               i_arvalid,
    output logic                    o_arready,
    output logic [31:0]             o_rdata,
    output logic [1:0]              o_rresp,
    output logic                    o_rvalid,
    input  wire logic               i_rready,
    // events and status
    output logic                    o_rx_irq,
    output logic [3:0]              o_buf_full
);
    localparam int NB = crb_pkg::NBUF;
    localparam int NF = crb_pkg::NFLT;

    crb_pkg::crb_frame_t assembly_buffer_r;
    logic                asm_pend_r;
    logic                asm_err_r;
    logic [1:0]          opmode_r;
    logic                irq_en_r;
    logic                ovf_r;
    logic [NB-1:0]       txsel_r;
    crb_pkg::crb_frame_t buf_r        [NB];
    logic [NB-1:0]       buffer_full_flag_r;
    logic [4:0]          filter_hit_index_r [NB];
    logic [1:0]          receive_mode_field_r [NB];
    logic                fwd_en_r;
    logic [28:0]         flt_id_r     [NF];
    logic                filter_extended_select_r [NF];
    logic [1:0]          flt_buf_r    [NF];
    logic                flt_msk_r    [NF];
    logic                flt_en_r     [NF];
    logic [28:0]         msk_id_r     [crb_pkg::NMSK];
    logic                msk_typ_r    [crb_pkg::NMSK];
    logic                awrdy_r;
    logic                wrdy_r;
    logic [11:0]         awaddr_r;
    logic [31:0]         wdata_r;
    logic [3:0]          wstrb_r;
    logic                bvalid_r;
    logic [1:0]          bresp_r;
    logic                arrdy_r;
    logic                rvalid_r;
    logic [1:0]          rresp_r;
    logic [31:0]         rdata_r;
    logic                irq_r;

    // register read decode: {ok, data}
    function automatic logic [32:0] rd_word(input logic [11:0] a);
        logic [32:0] r;
        logic [1:0]  b;
        logic [3:0]  f;
        r = 33'h0_0000_0000;
        b = a[6:5];
        f = a[6:3];
        case (a[11:8])
            crb_pkg::RGN_GLOB: begin
                if (a == crb_pkg::REG_CFG)
                    r = {1'b1, 29'h0, irq_en_r, opmode_r};
                else if (a == crb_pkg::REG_STAT)
                    r = {1'b1, 31'h0, ovf_r};
                else if (a == crb_pkg::REG_TXSEL)
                    r = {1'b1, 28'h0, txsel_r};
            end
            crb_pkg::RGN_BUF: begin
                if (!a[7]) begin
                    case (a[4:2])
                        crb_pkg::BW_CTRL: r = {1'b1, 22'h0, fwd_en_r && b == 2'h0,
                            receive_mode_field_r[b], filter_hit_index_r[b], buf_r[b].rtr,
                            buffer_full_flag_r[b]};
                        crb_pkg::BW_ID:   r = {1'b1, 2'h0, buf_r[b].ext, buf_r[b].id};
                        crb_pkg::BW_DLC:  r = {1'b1, 28'h0, buf_r[b].dlc};
                        crb_pkg::BW_DLO:  r = {1'b1, buf_r[b].data[31:0]};
                        crb_pkg::BW_DHI:  r = {1'b1, buf_r[b].data[63:32]};
                        default:          r = 33'h0_0000_0000;
                    endcase
                end
            end
            crb_pkg::RGN_FLT: begin
                if (!a[7] && !a[2])
                    r = {1'b1, 2'h0, filter_extended_select_r[f], flt_id_r[f]};
                else if (!a[7])
                    r = {1'b1, 28'h0, flt_en_r[f], flt_msk_r[f], flt_buf_r[f]};
            end
            crb_pkg::RGN_MSK: begin
                if (a[7:3] == 5'h00)
                    r = {1'b1, 2'h0, msk_typ_r[a[2]], msk_id_r[a[2]]};
            end
            default: r = 33'h0_0000_0000;
        endcase
        return r;
    endfunction : rd_word

    // acceptance evaluation on the assembly buffer
    logic          prog;
    logic [NF-1:0] fhit;
    logic [NB-1:0] acc;
    logic [NB-1:0] rxall;
    logic [4:0]    hidx [NB];
    logic          txdis;
    logic          any_acc;
    logic [1:0]    first;
    logic          fwd_sel;
    logic          do_load;
    logic          do_ovf;
    logic [1:0]    tgt;
    logic [4:0]    tgt_hit;

    always_comb begin
        logic       msel;
        logic       tok;
        logic [2:0] own;
        logic [NB-1:0] fb;
        msel = 1'b0;
        tok = 1'b0;
        own = 3'h4;
        fb = '0;
        prog = opmode_r != crb_pkg::OPM_FIXED;
        txdis = 1'b0;
        for (int b = 0; b < NB; b++) begin
            hidx[b] = 5'h00;
            rxall[b] = prog ? receive_mode_field_r[b][1] :
                       (receive_mode_field_r[b] == crb_pkg::RXM_ALL && b < 2);
        end
        fb = '0;
        for (int f = NF - 1; f >= 0; f--) begin
            msel = prog ? flt_msk_r[f] : (f >= crb_pkg::NFLT_M0_B0);
            tok = (prog && !msk_typ_r[msel]) ||
                  (assembly_buffer_r.ext == filter_extended_select_r[f]);
            fhit[f] = flt_en_r[f] && tok &&
                      (((assembly_buffer_r.id ^ flt_id_r[f]) & msk_id_r[msel]) == 29'h0);
            if (prog)
                own = {1'b0, flt_buf_r[f]};
            else if (f < crb_pkg::NFLT_M0_B0)
                own = 3'h0;
            else if (f < crb_pkg::NFLT_M0_B0 + crb_pkg::NFLT_M0_B1)
                own = 3'h1;
            else
                own = 3'h4;
            if (fhit[f] && !own[2]) begin
                fb[own[1:0]] = 1'b1;
                hidx[own[1:0]] = f[4:0];
                if (prog && txsel_r[own[1:0]])
                    txdis = 1'b1;
            end
        end
        for (int b = 0; b < NB; b++) begin
            tok = prog || receive_mode_field_r[b] == crb_pkg::RXM_FILT ||
                  (receive_mode_field_r[b] == crb_pkg::RXM_STD && !assembly_buffer_r.ext) ||
                  (receive_mode_field_r[b] == crb_pkg::RXM_EXT && assembly_buffer_r.ext);
            acc[b] = rxall[b] || (fb[b] && tok && !asm_err_r && (prog || b < 2));
        end
        any_acc = |acc;
        first = 2'h0;
        for (int b = NB - 1; b >= 0; b--)
            if (acc[b])
                first = b[1:0];
        fwd_sel = !prog && first == 2'h0 && buffer_full_flag_r[0] &&
                  fwd_en_r && !buffer_full_flag_r[1];
        do_load = asm_pend_r && !txdis && any_acc &&
                  (!buffer_full_flag_r[first] || fwd_sel);
        do_ovf = asm_pend_r && !txdis && any_acc && !do_load;
        tgt = fwd_sel ? 2'h1 : first;
        tgt_hit = prog ? hidx[first] : {1'b0, hidx[first][3:0]};
    end

    // assembly buffer: always free for the next message
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            assembly_buffer_r <= '0;
            asm_pend_r <= 1'b0;
            asm_err_r <= 1'b0;
        end else begin
            asm_pend_r <= i_frame_done || i_frame_err;
            if (i_frame_done || i_frame_err) begin
                assembly_buffer_r <= i_frame;
                asm_err_r <= i_frame_err && !i_frame_done;
            end
        end
    end

    // axi write channel
    logic [32:0] wr_cur;
    logic [31:0] wr_bm;
    logic [31:0] wr_val;
    logic        wr_fire;
    logic [3:0]  wr_f;
    logic [1:0]  wr_b;

    always_comb begin
        wr_cur = rd_word(awaddr_r);
        wr_bm = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
        wr_val = (wr_cur[31:0] & ~wr_bm) | (wdata_r & wr_bm);
        wr_fire = !awrdy_r && !wrdy_r && !bvalid_r;
        wr_f = awaddr_r[6:3];
        wr_b = awaddr_r[6:5];
    end

    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            awrdy_r <= 1'b1;
            wrdy_r <= 1'b1;
            awaddr_r <= 12'h000;
            wdata_r <= 32'h0000_0000;
            wstrb_r <= 4'h0;
            bvalid_r <= 1'b0;
            bresp_r <= crb_pkg::RESP_OKAY;
        end else begin
            if (i_awvalid && awrdy_r) begin
                awaddr_r <= i_awaddr;
                awrdy_r <= 1'b0;
            end
            if (i_wvalid && wrdy_r) begin
                wdata_r <= i_wdata;
                wstrb_r <= i_wstrb;
                wrdy_r <= 1'b0;
            end
            if (wr_fire) begin
                bvalid_r <= 1'b1;
                bresp_r <= wr_cur[32] ? crb_pkg::RESP_OKAY : crb_pkg::RESP_SLVERR;
            end else if (bvalid_r && i_bready) begin
                bvalid_r <= 1'b0;
                awrdy_r <= 1'b1;
                wrdy_r <= 1'b1;
            end
        end
    end

    // global configuration and overflow status
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            opmode_r <= crb_pkg::OPM_FIXED;
            irq_en_r <= 1'b0;
            txsel_r <= '0;
            ovf_r <= 1'b0;
        end else begin
            if (wr_fire && wr_cur[32] && awaddr_r == crb_pkg::REG_CFG) begin
                opmode_r <= wr_val[1:0];
                irq_en_r <= wr_val[crb_pkg::CFG_IRQEN];
            end
            if (wr_fire && wr_cur[32] && awaddr_r == crb_pkg::REG_TXSEL)
                txsel_r <= wr_val[NB-1:0];
            // set beats a same-cycle clear so no overflow goes unseen
            if (do_ovf)
                ovf_r <= 1'b1;
            else if (wr_fire && awaddr_r == crb_pkg::REG_STAT &&
                     wstrb_r[0] && wdata_r[crb_pkg::STAT_OVF])
                ovf_r <= 1'b0;
        end
    end

    // filters and masks
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            for (int f = 0; f < NF; f++) begin
                flt_id_r[f] <= 29'h0;
                filter_extended_select_r[f] <= 1'b0;
                flt_buf_r[f] <= 2'h0;
                flt_msk_r[f] <= 1'b0;
                flt_en_r[f] <= 1'b0;
            end
            for (int m = 0; m < crb_pkg::NMSK; m++) begin
                msk_id_r[m] <= 29'h0;
                msk_typ_r[m] <= 1'b0;
            end
        end else if (wr_fire && wr_cur[32]) begin
            if (awaddr_r[11:8] == crb_pkg::RGN_FLT && !awaddr_r[2]) begin
                flt_id_r[wr_f] <= wr_val[28:0];
                filter_extended_select_r[wr_f] <= wr_val[crb_pkg::ID_EXT];
            end else if (awaddr_r[11:8] == crb_pkg::RGN_FLT) begin
                flt_buf_r[wr_f] <= wr_val[1:0];
                flt_msk_r[wr_f] <= wr_val[crb_pkg::FA_MSK];
                flt_en_r[wr_f] <= wr_val[crb_pkg::FA_EN];
            end else if (awaddr_r[11:8] == crb_pkg::RGN_MSK) begin
                msk_id_r[awaddr_r[2]] <= wr_val[28:0];
                msk_typ_r[awaddr_r[2]] <= wr_val[crb_pkg::ID_EXT];
            end
        end
    end

    // receive buffers: transfer, full lockout, firmware release
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            for (int b = 0; b < NB; b++) begin
                buf_r[b] <= '0;
                filter_hit_index_r[b] <= 5'h00;
                receive_mode_field_r[b] <= crb_pkg::RXM_RST;
            end
            buffer_full_flag_r <= '0;
            fwd_en_r <= 1'b0;
        end else begin
            if (wr_fire && wr_cur[32] && awaddr_r[11:8] == crb_pkg::RGN_BUF &&
                awaddr_r[4:2] == crb_pkg::BW_CTRL) begin
                receive_mode_field_r[wr_b] <= wr_val[crb_pkg::CTRL_RXM +: 2];
                if (wr_b == 2'h0)
                    fwd_en_r <= wr_val[crb_pkg::CTRL_FWD];
                if (!wr_val[crb_pkg::CTRL_FULL])
                    buffer_full_flag_r[wr_b] <= 1'b0;
            end
            // a load in the release cycle keeps the flag set
            if (do_load) begin
                buf_r[tgt] <= assembly_buffer_r;
                filter_hit_index_r[tgt] <= tgt_hit;
                buffer_full_flag_r[tgt] <= 1'b1;
            end
        end
    end

    // axi read channel
    logic [32:0] rd_ar;
    always_comb rd_ar = rd_word(i_araddr);

    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            arrdy_r <= 1'b1;
            rvalid_r <= 1'b0;
            rresp_r <= crb_pkg::RESP_OKAY;
            rdata_r <= 32'h0000_0000;
        end else if (i_arvalid && arrdy_r) begin
            arrdy_r <= 1'b0;
            rvalid_r <= 1'b1;
            rdata_r <= rd_ar[31:0];
            rresp_r <= rd_ar[32] ? crb_pkg::RESP_OKAY : crb_pkg::RESP_SLVERR;
        end else if (rvalid_r && i_rready) begin
            rvalid_r <= 1'b0;
            arrdy_r <= 1'b1;
        end
    end

    // receive event pulse
    always_ff @(posedge i_mclk) begin
        if (i_reset)
            irq_r <= 1'b0;
        else
            irq_r <= do_load && irq_en_r;
    end

    assign o_awready  = awrdy_r;
    assign o_wready   = wrdy_r;
    assign o_bvalid   = bvalid_r;
    assign o_bresp    = bresp_r;
    assign o_arready  = arrdy_r;
    assign o_rvalid   = rvalid_r;
    assign o_rresp    = rresp_r;
    assign o_rdata    = rdata_r;
    assign o_rx_irq   = irq_r;
    assign o_buf_full = buffer_full_flag_r;

    sequence s_load;
        do_load;
    endsequence
    sequence s_stored(logic [1:0] t);
        buffer_full_flag_r[t] ##0 o_buf_full[t];
    endsequence

    property p_full_set;
        @(posedge i_mclk) disable iff (i_reset) s_load |=> s_stored($past(tgt));
    endproperty
    a_full_set: assert property (p_full_set) else $error("full flag not set on load");
    property p_no_overwrite;
        @(posedge i_mclk) disable iff (i_reset) do_load |-> !buffer_full_flag_r[tgt] || fwd_sel;
    endproperty
    a_no_overwrite: assert property (p_no_overwrite) else $error("full buffer loaded");
    property p_copy;
        @(posedge i_mclk) disable iff (i_reset)
            s_load |=> buf_r[$past(tgt)] == $past(assembly_buffer_r);
    endproperty
    a_copy: assert property (p_copy) else $error("buffer differs from assembly");
    property p_irq;
        @(posedge i_mclk) disable iff (i_reset) o_rx_irq == $past(do_load && irq_en_r);
    endproperty
    a_irq: assert property (p_irq) else $error("receive pulse wrong");
    property p_capture;
        @(posedge i_mclk) disable iff (i_reset)
            i_frame_done |=> asm_pend_r && assembly_buffer_r == $past(i_frame);
    endproperty
    a_capture: assert property (p_capture) else $error("message not captured");
    property p_ovf;
        @(posedge i_mclk) disable iff (i_reset) do_ovf |=> ovf_r;
    endproperty
    a_ovf: assert property (p_ovf) else $error("overflow lost");
    property p_prio;
        @(posedge i_mclk) disable iff (i_reset)
            do_load && !fwd_sel |-> (acc & ((4'h1 << tgt) - 4'h1)) == 4'h0;
    endproperty
    a_prio: assert property (p_prio) else $error("lower buffer skipped");
    property p_err_frame;
        @(posedge i_mclk) disable iff (i_reset) do_load && asm_err_r |-> rxall[tgt];
    endproperty
    a_err_frame: assert property (p_err_frame) else $error("errored frame in filtered buffer");
    property p_txdis;
        @(posedge i_mclk) disable iff (i_reset) txdis |-> !do_load && !do_ovf;
    endproperty
    a_txdis: assert property (p_txdis) else $error("transmit-owned hit loaded");
    property p_hit4;
        @(posedge i_mclk) disable iff (i_reset)
            do_load && !prog |=> !filter_hit_index_r[$past(tgt)][4];
    endproperty
    a_hit4: assert property (p_hit4) else $error("hit index too wide");
endmodule : crb_rx_ctrl
`default_nettype wire

// ---- shared/crb_pkg.sv ----
package crb_pkg;
    // structure sizes
    localparam int NBUF = 4;
    localparam int NFLT = 16;
    localparam int NMSK = 2;
    localparam int NFLT_M0_B0 = 2;
    localparam int NFLT_M0_B1 = 4;

    // one assembled bus message; byte k of the payload sits at data[8k+7:8k]
    typedef struct packed {
        logic        ext;
        logic        rtr;
        logic [3:0]  dlc;
        logic [28:0] id;
        logic [63:0] data;
    } crb_frame_t;

    // controller operating modes
    localparam logic [1:0] OPM_FIXED = 2'h0;
    localparam logic [1:0] OPM_PROG1 = 2'h1;
    localparam logic [1:0] OPM_PROG2 = 2'h2;

    // receive mode field values
    localparam logic [1:0] RXM_FILT = 2'h0;
    localparam logic [1:0] RXM_STD  = 2'h1;
    localparam logic [1:0] RXM_EXT  = 2'h2;
    localparam logic [1:0] RXM_ALL  = 2'h3;

    // byte offsets and regions
    localparam logic [11:0] REG_CFG   = 12'h000;
    localparam logic [11:0] REG_STAT  = 12'h004;
    localparam logic [11:0] REG_TXSEL = 12'h008;
    localparam logic [3:0]  RGN_GLOB  = 4'h0;
    localparam logic [3:0]  RGN_BUF   = 4'h1;
    localparam logic [3:0]  RGN_FLT   = 4'h2;
    localparam logic [3:0]  RGN_MSK   = 4'h3;

    // word index inside one buffer (stride 0x20)
    localparam logic [2:0] BW_CTRL = 3'h0;
    localparam logic [2:0] BW_ID   = 3'h1;
    localparam logic [2:0] BW_DLC  = 3'h2;
    localparam logic [2:0] BW_DLO  = 3'h3;
    localparam logic [2:0] BW_DHI  = 3'h4;

    // field positions
    localparam int CTRL_FULL = 0;
    localparam int CTRL_RTR  = 1;
    localparam int CTRL_HIT  = 2;
    localparam int CTRL_RXM  = 7;
    localparam int CTRL_FWD  = 9;
    localparam int ID_EXT    = 29;
    localparam int CFG_IRQEN = 2;
    localparam int STAT_OVF  = 0;
    localparam int FA_EN     = 3;
    localparam int FA_MSK    = 2;

    // reset values and responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [1:0] RXM_RST     = 2'h0;
endpackage : crb_pkg

// ---- test/crb_engine_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module crb_engine_model (
    // clock
    input  wire logic              i_mclk,
    // frame handoff
    output var crb_pkg::crb_frame_t o_frame,
    output var logic               o_done,
    output var logic               o_err
);
    crb_pkg::crb_frame_t fq[$];
    logic                eq[$];
    initial begin
        o_frame = '0;
        o_done = 1'b0;
        o_err = 1'b0;
    end
    task push(input crb_pkg::crb_frame_t f, input logic e);
        fq.push_back(f);
        eq.push_back(e);
    endtask : push
    // one frame per cycle, back to back when queued
    always @(posedge i_mclk) begin
        if (fq.size() > 0) begin
            o_frame <= fq.pop_front();
            o_err   <= eq[0];
            o_done  <= !eq.pop_front();
        end else begin
            // stale bits flip so nothing leans on held content
            o_frame <= ~o_frame;
            o_done  <= 1'b0;
            o_err   <= 1'b0;
        end
    end
endmodule : crb_engine_model
`default_nettype wire

// ---- test/tb_can_receive_buffer_control.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_can_receive_buffer_control;
    logic clk = 0, rst = 1, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0;
    logic [11:0] awa = '0, ara = '0;
    logic [31:0] wd = '0, rdata;
    logic aw_rdy, w_rdy, b_vld, ar_rdy, r_vld, irq, fd, fe;
    logic [1:0] bresp, rresp;
    logic [3:0] full;
    crb_pkg::crb_frame_t fr, a, b, c, d, e;
    logic [33:0] rq[$];
    logic [1:0] bq[$];
    int err_total = 0, cmp_count = 0, irq_n = 0, seed = 32'h9b1e;
    initial forever #5 clk = ~clk;
    crb_engine_model crb_engine_model_inst (.i_mclk(clk), .o_frame(fr), .o_done(fd), .o_err(fe));
    crb_rx_ctrl crb_rx_ctrl_inst (.i_mclk(clk), .i_reset(rst), .i_frame(fr), .i_frame_done(fd),
        .i_frame_err(fe), .i_awaddr(awa), .i_awvalid(awv), .o_awready(aw_rdy), .i_wdata(wd),
        .i_wstrb(4'hf), .i_wvalid(wv), .o_wready(w_rdy), .o_bresp(bresp), .o_bvalid(b_vld),
        .i_bready(bre), .i_araddr(ara), .i_arvalid(arv), .o_arready(ar_rdy), .o_rdata(rdata),
        .o_rresp(rresp), .o_rvalid(r_vld), .i_rready(rre), .o_rx_irq(irq), .o_buf_full(full));
    task results;
        if (err_total == 0 && cmp_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : results
    task chk(input string nm, input logic [33:0] s, input logic [33:0] x);
        cmp_count++;
        if (s !== x) begin
            err_total++;
            $display("wrong value %s exp %h seen %h", nm, x, s);
        end
    endtask : chk
    task tmo(input int n);
        if (n >= 50) begin
            err_total++;
            $display("wrong value handshake exp answer seen none");
            results();
        end
    endtask : tmo
    // monitor: oldest note against each answer
    always @(posedge clk) begin
        if (b_vld && bre) chk("bresp", {32'h0, bresp}, {32'h0, bq.pop_front()});
        if (r_vld && rre) chk("read", {rresp, rdata}, rq.pop_front());
        if (irq === 1'b1) irq_n++;
    end
    task wr(input logic [11:0] ad, input logic [31:0] dt, input logic [1:0] rs);
        int n;
        bq.push_back(rs);
        @(posedge clk);
        awa <= ad;
        wd <= dt;
        awv <= 1'b1;
        wv <= 1'b1;
        bre <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk);
            if (aw_rdy) awv <= 1'b0;
            if (w_rdy) wv <= 1'b0;
            if (b_vld) break;
        end
        tmo(n);
        bre <= 1'b0;
    endtask : wr
    task rd(input logic [11:0] ad, input logic [31:0] dt, input logic [1:0] rs);
        int n;
        rq.push_back({rs, dt});
        @(posedge clk);
        ara <= ad;
        arv <= 1'b1;
        rre <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk);
            if (ar_rdy) arv <= 1'b0;
            if (r_vld) break;
        end
        tmo(n);
        rre <= 1'b0;
    endtask : rd
    function automatic crb_pkg::crb_frame_t mk(input logic x, input logic r);
        crb_pkg::crb_frame_t f;
        f.data = {$random(seed), $random(seed)};
        f.id = x ? 29'($random(seed)) : {18'h0, 11'($random(seed))};
        f.ext = x;
        f.rtr = r;
        f.dlc = 4'($random(seed));
        return f;
    endfunction : mk
    // load latency is fixed: three edges plus margin
    task snd(input crb_pkg::crb_frame_t f, input logic er, input logic last);
        @(negedge clk);
        crb_engine_model_inst.push(f, er);
        if (last) repeat (5) @(posedge clk);
    endtask : snd
    task chkbuf(input logic [11:0] bs, input crb_pkg::crb_frame_t f, input logic [4:0] h,
                input logic [1:0] m);
        rd(bs, {23'h0, m, h, f.rtr, 1'b1}, 2'h0);
        rd(bs + 12'h004, {2'h0, f.ext, f.id}, 2'h0);
        rd(bs + 12'h008, {28'h0, f.dlc}, 2'h0);
        rd(bs + 12'h00c, f.data[31:0], 2'h0);
        rd(bs + 12'h010, f.data[63:32], 2'h0);
    endtask : chkbuf
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        wr(12'h000, 32'h0000_0004, 2'h0);
        wr(12'h204, 32'h0000_0008, 2'h0);
        wr(12'h210, 32'h2000_0000, 2'h0);
        wr(12'h214, 32'h0000_0008, 2'h0);
        a = mk(1'b0, 1'b1);
        snd(a, 1'b0, 1'b1);
        chkbuf(12'h100, a, 5'h0, 2'h0);
        b = mk(1'b0, 1'b0);
        snd(b, 1'b0, 1'b1);
        rd(12'h004, 32'h0000_0001, 2'h0);
        rd(12'h104, {2'h0, a.ext, a.id}, 2'h0);
        wr(12'h004, 32'h0000_0001, 2'h0);
        wr(12'h100, 32'h0000_0201, 2'h0);
        c = mk(1'b0, 1'b0);
        snd(c, 1'b0, 1'b1);
        chkbuf(12'h120, c, 5'h0, 2'h0);
        rd(12'h004, 32'h0000_0000, 2'h0);
        wr(12'h100, 32'h0000_0000, 2'h0);
        wr(12'h120, 32'h0000_0000, 2'h0);
        chk("full", {30'h0, full}, 34'h0);
        d = mk(1'b1, 1'b0);
        e = mk(1'b0, 1'b1);
        snd(d, 1'b0, 1'b0);
        snd(e, 1'b0, 1'b1);
        chkbuf(12'h120, d, 5'h2, 2'h0);
        chkbuf(12'h100, e, 5'h0, 2'h0);
        wr(12'h100, 32'h0000_0000, 2'h0);
        wr(12'h120, 32'h0000_0180, 2'h0);
        c = mk(1'b0, 1'b0);
        snd(c, 1'b1, 1'b1);
        chk("full", {30'h0, full}, 34'h2);
        chkbuf(12'h120, c, 5'h0, 2'h3);
        wr(12'h120, 32'h0000_0180, 2'h0);
        b = mk(1'b0, 1'b0);
        snd(b, 1'b0, 1'b1);
        chk("full", {30'h0, full}, 34'h1);
        wr(12'h100, 32'h0000_0100, 2'h0);
        b = mk(1'b0, 1'b0);
        snd(b, 1'b0, 1'b1);
        chk("full", {30'h0, full}, 34'h2);
        rd(12'h00c, 32'h0000_0000, 2'h2);
        wr(12'h00c, 32'hffff_ffff, 2'h2);
        wr(12'h120, 32'h0000_0000, 2'h0);
        wr(12'h100, 32'h0000_0000, 2'h0);
        wr(12'h000, 32'h0000_0005, 2'h0);
        wr(12'h008, 32'h0000_0001, 2'h0);
        b = mk(1'b0, 1'b0);
        snd(b, 1'b0, 1'b1);
        chk("full", {30'h0, full}, 34'h0);
        wr(12'h008, 32'h0000_0000, 2'h0);
        b = mk(1'b1, 1'b0);
        snd(b, 1'b0, 1'b1);
        chkbuf(12'h100, b, 5'h0, 2'h0);
        chk("irq", 34'(irq_n), 34'h8);
        results();
    end
endmodule : tb_can_receive_buffer_control
`default_nettype wire
